// ### src/pll_status_defines.vh
// What this block does
// (RULE1) Bit 6: VCO calibration finished flag
// (RULE2) Bit 5: PLL currently in holdover
// (RULE3) Holdover flag ignores holdover enable setting
// (RULE4) Bit 4: one when reference two selected
// (RULE5) Differential reference mode reads select as zero
// (RULE6) Bit 3: VCO frequency above monitor threshold
// (RULE7) Bit 2: reference two above selected threshold
// (RULE8) Bit 1: reference one above selected threshold
// (RULE9) Bit 0: digital lock detect
// (RULE10) Writes ignored; bit 7 zero; live status
`ifndef PLL_STATUS_DEFINES_VH
`define PLL_STATUS_DEFINES_VH

// ==========================================================
// Register offsets (byte addresses are four times the index)
`define STATUS_IDX 10'h01f
`define THRESH_CFG_IDX 10'h01a
`define IRQ_STATUS_IDX 10'h100
`define IRQ_MASK_IDX 10'h101
`define THRESH_SEL_BIT 6

// ==========================================================
// Status field positions
`define ST_CAL_DONE 6
`define ST_HOLDOVER 5
`define ST_REF_TWO 4
`define ST_VCO_OVER 3
`define ST_REF_TWO_OVER 2
`define ST_REF_ONE_OVER 1
`define ST_LOCKED 0

// ==========================================================
// Reset values
`define STATUS_RST 8'h00
`define THRESH_CFG_RST 8'h00
`define THRESH_SEL_RST 1'b0
`define IRQ_STATUS_RST 8'h00
`define IRQ_MASK_RST 8'h00

`endif

// ### src/pll_status_readback.v
`timescale 1ns/100ps
`include "pll_status_defines.vh"

module pll_status_readback (
  input wire clk_i, // Clock, 20 MHz
  input wire rst_i, // Synchronous reset, active high
  input wire ce_i, // Clock enable, freezes state when low
  input wire cyc_i, // Wishbone cycle
  input wire stb_i, // Wishbone strobe
  input wire we_i, // Wishbone write enable
  input wire [11:0] adr_i, // Wishbone byte address
  input wire [3:0] sel_i, // Wishbone byte selects
  input wire [31:0] dat_i, // Wishbone write data
  output reg [31:0] dat_o, // Wishbone read data
  output reg ack_o, // Wishbone acknowledge
  output reg irq_o, // Level interrupt
  output reg thresh_sel_o, // Frequency monitor threshold select
  input wire cal_done_i, // VCO calibration finished
  input wire holdover_active_i, // PLL in holdover state
  input wire reference_input_two_sel_i, // Reference two selected
  input wire differential_mode_i, // Differential reference mode
  input wire vco_over_i, // VCO above threshold
  input wire reference_input_two_over_i, // Reference two above threshold
  input wire reference_input_one_over_i, // Reference one above threshold
  input wire locked_i // Digital lock detect
);

  // ==========================================================
  // Bus handshake states
  // BUS_IDLE waits for a strobe, BUS_ACK answers it for one cycle
  localparam [1:0] BUS_IDLE = 2'b00;
  localparam [1:0] BUS_ACK = 2'b01;

  // ==========================================================
  // Helpers
  // Register index match
  function idx_is;
    input [9:0] idx_in;
    input [9:0] target_in;
  begin
    idx_is = (idx_in == target_in);
  end
  endfunction

  // Write strobe, low byte lane only
  function wr_strobe;
    input req_in;
    input we_in;
    input lane_in;
    input hit_in;
  begin
    wr_strobe = req_in & we_in & lane_in & hit_in;
  end
  endfunction

  // Places an 8-bit register in the low byte of the bus word
  function [31:0] byte_word;
    input [7:0] value_in;
  begin
    byte_word = {24'h000000, value_in};
  end
  endfunction

  // Bits that differ between two samples, once history is valid
  function [7:0] change_events;
    input [7:0] now_in;
    input [7:0] prev_in;
    input valid_in;
  begin
    change_events = valid_in ? (now_in ^ prev_in) : 8'h00;
  end
  endfunction

  // Write-one-to-clear, then set; a set wins over the clear
  function [7:0] sticky_next;
    input [7:0] held_in;
    input [7:0] clear_in;
    input clear_en_in;
    input [7:0] set_in;
    reg [7:0] kept;
  begin
    kept = held_in;
    if (clear_en_in)
      kept = held_in & ~clear_in;
    sticky_next = kept | set_in;
  end
  endfunction

  // ==========================================================
  // Internal signals
  wire [7:0] status;
  reg [7:0] status_prev_r;
  reg [1:0] prime_r;
  reg [7:0] thresh_cfg_r;
  reg [7:0] irq_status_r;
  reg [7:0] irq_mask_r;
  reg [7:0] irq_status_nxt;
  reg irq_pending;
  reg [1:0] bus_state_r;
  reg [1:0] bus_state_nxt;
  reg [31:0] rd_nxt;
  reg [7:0] events;
  wire history_ok;
  wire req;
  wire rd_req;
  wire lane_lo;
  wire [9:0] idx;
  wire hit_status;
  wire hit_thresh;
  wire hit_irq_status;
  wire hit_mask;
  wire wr_thresh;
  wire wr_mask;
  wire wr_irq_clr;

  // ==========================================================
  // Status sampling
  // The sampler registers the pins once per enabled clock
  status_sampler u_sampler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cal_done_i(cal_done_i),
    .holdover_active_i(holdover_active_i),
    .reference_input_two_sel_i(reference_input_two_sel_i),
    .differential_mode_i(differential_mode_i),
    .vco_over_i(vco_over_i),
    .reference_input_two_over_i(reference_input_two_over_i),
    .reference_input_one_over_i(reference_input_one_over_i),
    .locked_i(locked_i),
    .status_o(status)
  );

  // ==========================================================
  // Start-up qualification
  // The first sample after reset has no valid predecessor, so
  // change events wait until two samples have been taken
  assign history_ok = prime_r[1];

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prime_r <= 2'b00;
    end
    else if (ce_i)
    begin
      prime_r <= {prime_r[0], 1'b1};
    end
  end

  // Previous sample for change detection
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_prev_r <= `STATUS_RST;
    end
    else if (ce_i)
    begin
      status_prev_r <= status;
    end
  end

  // ==========================================================
  // Bus decode
  // Only the low byte lane carries register data
  assign req = cyc_i & stb_i & (bus_state_r == BUS_IDLE);
  assign rd_req = req & ~we_i;
  assign idx = adr_i[11:2];
  assign lane_lo = sel_i[0];
  assign hit_status = idx_is(idx, `STATUS_IDX);
  assign hit_thresh = idx_is(idx, `THRESH_CFG_IDX);
  assign hit_irq_status = idx_is(idx, `IRQ_STATUS_IDX);
  assign hit_mask = idx_is(idx, `IRQ_MASK_IDX);
  // The status index has no write strobe, so writes to it are lost
  assign wr_thresh = wr_strobe(req, we_i, lane_lo, hit_thresh);
  assign wr_mask = wr_strobe(req, we_i, lane_lo, hit_mask);
  assign wr_irq_clr = wr_strobe(req, we_i, lane_lo, hit_irq_status);

  // ==========================================================
  // Bus handshake
  // A request is taken only in BUS_IDLE, so a strobe still held
  // during the acknowledge cycle is not taken twice
  always @*
  begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      BUS_IDLE:
      begin
        if (req)
          bus_state_nxt = BUS_ACK;
      end
      BUS_ACK:
      begin
        bus_state_nxt = BUS_IDLE;
      end
      default:
      begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state_r <= BUS_IDLE;
      ack_o <= 1'b0;
    end
    else if (ce_i)
    begin
      bus_state_r <= bus_state_nxt;
      ack_o <= (bus_state_nxt == BUS_ACK);
    end
  end

  // ==========================================================
  // Read data
  // Unmapped indices read as zero
  always @*
  begin
    if (hit_status)
      rd_nxt = byte_word(status); // RULE10
    else if (hit_thresh)
      rd_nxt = byte_word(thresh_cfg_r);
    else if (hit_irq_status)
      rd_nxt = byte_word(irq_status_r);
    else if (hit_mask)
      rd_nxt = byte_word(irq_mask_r);
    else
      rd_nxt = 32'h00000000;
  end

  // Read data holds until the next read is taken
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h00000000;
    end
    else if (ce_i && rd_req)
    begin
      dat_o <= rd_nxt;
    end
  end

  // ==========================================================
  // Threshold configuration
  // Only bit 6 has a use; the other bits are kept for readback
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thresh_cfg_r <= `THRESH_CFG_RST;
    end
    else if (ce_i && wr_thresh)
    begin
      thresh_cfg_r <= dat_i[7:0];
    end
  end

  // The monitors see the select one cycle after the register
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thresh_sel_o <= `THRESH_SEL_RST;
    end
    else if (ce_i)
    begin
      thresh_sel_o <= thresh_cfg_r[`THRESH_SEL_BIT]; // RULE7 RULE8
    end
  end

  // ==========================================================
  // Change events
  // Either direction of change in a status bit is an event
  always @*
  begin
    events = change_events(status, status_prev_r, history_ok);
  end

  // ==========================================================
  // Interrupt status and mask
  always @*
  begin
    irq_status_nxt = sticky_next(irq_status_r, dat_i[7:0],
                                 wr_irq_clr, events);
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status_r <= `IRQ_STATUS_RST;
    end
    else if (ce_i)
    begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // Mask bits follow the status layout
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_mask_r <= `IRQ_MASK_RST;
    end
    else if (ce_i && wr_mask)
    begin
      irq_mask_r <= dat_i[7:0];
    end
  end

  // ==========================================================
  // Interrupt pending
  // Taken from the next status so a new event raises the line
  // one cycle after it is seen
  always @*
  begin
    irq_pending = |(irq_status_nxt & irq_mask_r);
  end

  // ==========================================================
  // Interrupt request
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_o <= irq_pending;
    end
  end

endmodule // pll_status_readback

// ### src/status_sampler.v
`timescale 1ns/100ps
`include "pll_status_defines.vh"

module status_sampler (
  input wire clk_i, // Clock
  input wire rst_i, // Synchronous reset
  input wire ce_i, // Clock enable
  input wire cal_done_i, // VCO calibration finished
  input wire holdover_active_i, // PLL in holdover state
  input wire reference_input_two_sel_i, // Reference two selected
  input wire differential_mode_i, // Differential reference mode
  input wire vco_over_i, // VCO above threshold
  input wire reference_input_two_over_i, // Reference two above threshold
  input wire reference_input_one_over_i, // Reference one above threshold
  input wire locked_i, // Digital lock detect
  output reg [7:0] status_o // Sampled status byte
);

  always @(posedge clk_i)
  begin
    if (rst_i)
      status_o <= `STATUS_RST;
    else if (ce_i)
    begin
      status_o[7] <= 1'b0; // RULE10
      status_o[`ST_CAL_DONE] <= cal_done_i; // RULE1
      // Only the live state counts, not the enable
      status_o[`ST_HOLDOVER] <= holdover_active_i; // RULE2 RULE3
      status_o[`ST_REF_TWO] <= reference_input_two_sel_i &
                               ~differential_mode_i; // RULE4 RULE5
      status_o[`ST_VCO_OVER] <= vco_over_i; // RULE6
      status_o[`ST_REF_TWO_OVER] <= reference_input_two_over_i; // RULE7
      status_o[`ST_REF_ONE_OVER] <= reference_input_one_over_i; // RULE8
      status_o[`ST_LOCKED] <= locked_i; // RULE9
    end
  end

endmodule // status_sampler

// ### test/status_checker.sv
`timescale 1ns/100ps
// ==========================================
// Status byte read checks
module status_checker (
  input wire clk_i, // Clock
  input wire rst_i, // Synchronous reset
  input wire we_i, // Bus write enable
  input wire ack_o, // Bus acknowledge
  input wire [11:0] adr_i, // Bus byte address
  input wire [31:0] dat_o, // Bus read data
  input wire irq_o, // Level interrupt
  input wire cal_done_i, // VCO calibration finished
  input wire holdover_active_i, // PLL in holdover
  input wire reference_input_two_sel_i, // Reference two selected
  input wire differential_mode_i, // Differential reference mode
  input wire vco_over_i, // VCO above threshold
  input wire reference_input_two_over_i, // Reference two above threshold
  input wire reference_input_one_over_i, // Reference one above threshold
  input wire locked_i // Digital lock detect
);
  wire [7:0] sv = {1'h0, cal_done_i, holdover_active_i,
    reference_input_two_sel_i & ~differential_mode_i, vco_over_i,
    reference_input_two_over_i, reference_input_one_over_i, locked_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Status read acknowledged while the inputs sat still
  sequence rd;
    ack_o && !we_i && adr_i[11:2] == 10'h01f && !$past(rst_i, 3) &&
    sv == $past(sv) && sv == $past(sv, 2) && sv == $past(sv, 3);
  endsequence
  property bit_p(b);
    rd |-> dat_o[b] == sv[b];
  endproperty
  cal_done_a: assert property (bit_p(6)) else $error("cal bit");
  holdover_state_a: assert property (bit_p(5))
    else $error("hold bit");
  ref_select_a: assert property (bit_p(4))
    else $error("sel bit");
  vco_over_a: assert property (bit_p(3)) else $error("vco bit");
  ref_two_over_a: assert property (bit_p(2)) else $error("r2 bit");
  ref_one_over_a: assert property (bit_p(1)) else $error("r1 bit");
  lock_detect_a: assert property (bit_p(0)) else $error("lock bit");
  upper_zero_a: assert property (rd |-> dat_o[31:7] == 25'h0)
    else $error("upper bits");
  cover property (rd ##0 sv[5]);
  cover property (rd ##0 (differential_mode_i && reference_input_two_sel_i));
  cover property (rd ##0 sv[0]);
  cover property (!irq_o ##1 irq_o);
endmodule // status_checker

bind pll_status_readback status_checker i_status_checker (.*);

// ### test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, cyc_i = 1'h0;
  reg stb_i = 1'h0, we_i = 1'h0;
  reg [11:0] adr_i = 12'h0;
  reg [3:0] sel_i = 4'hf;
  reg [31:0] dat_i = 32'h0, rd;
  reg [7:0] p = 8'h0;
  wire [31:0] dat_o;
  wire ack_o, irq_o, thresh_sel_o, cal_done_i, holdover_active_i;
  wire reference_input_two_sel_i, differential_mode_i, vco_over_i;
  wire reference_input_two_over_i, reference_input_one_over_i, locked_i;
  integer n_errors = 0, compares = 0, i;
  assign {cal_done_i, holdover_active_i, reference_input_two_sel_i,
    differential_mode_i, vco_over_i, reference_input_two_over_i,
    reference_input_one_over_i, locked_i} = p;
  pll_status_readback i_pll_status_readback (.*);
  always #25 clk_i = ~clk_i;
  // ==========================================
  // Shared tasks
  task complete_run;
  begin
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
  begin
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  end
  endtask
  // Status word as the rules lay it out: bit 7 zero, select masked
  function [31:0] model_status(input [7:0] pins);
  begin
    model_status = {25'h0, pins[7:6], pins[5] & ~pins[4], pins[3:0]};
  end
  endfunction
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
  begin
    cyc_i <= 1'h1; stb_i <= 1'h1; we_i <= w; adr_i <= a; dat_i <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack_o !== 1'h1 && k < 20);
    rd = dat_o;
    if (ack_o !== 1'h1)
    begin
      n_errors++;
      complete_run;
    end
    cyc_i <= 1'h0; stb_i <= 1'h0;
    @(posedge clk_i);
  end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(48));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    for (i = 0; i < 40; i++)
    begin
      p <= (i < 8) ? 8'h1 << i : 8'($urandom);
      @(posedge clk_i);
      bus(1'h1, 12'h07c, $urandom);
      bus(1'h0, 12'h07c, 32'h0);
      chk(rd, model_status(p));
    end
    bus(1'h0, 12'h7f0, 32'h0);
    chk(rd, 32'h0);
    chk(thresh_sel_o, 1'h0);
    bus(1'h1, 12'h068, 32'h40);
    bus(1'h0, 12'h068, 32'h0);
    chk(rd, 32'h40);
    chk(thresh_sel_o, 1'h1);
    bus(1'h1, 12'h404, 32'h1);
    bus(1'h1, 12'h400, 32'hff);
    chk(irq_o, 1'h0);
    p[0] <= ~p[0];
    repeat (4) @(posedge clk_i);
    chk(irq_o, 1'h1);
    bus(1'h0, 12'h400, 32'h0);
    chk(rd, 32'h1);
    bus(1'h1, 12'h400, 32'hff);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'h0);
    // A change while the clock enable is low waits for it to rise
    ce_i <= 1'h0;
    p[0] <= ~p[0];
    repeat (4) @(posedge clk_i);
    chk(irq_o, 1'h0);
    ce_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    chk(irq_o, 1'h1);
    bus(1'h1, 12'h404, 32'h0);
    bus(1'h1, 12'h400, 32'hff);
    p[0] <= ~p[0];
    repeat (4) @(posedge clk_i);
    chk(irq_o, 1'h0);
    bus(1'h0, 12'h400, 32'h0);
    chk(rd, 32'h1);
    complete_run;
  end
endmodule // tb_top
